// ==== verilog/card_irq_pkg.sv ====
/*
 * Constants for the card interrupt and status control block: region sizes,
 * register offsets, bit positions, reset values.
 * Assumes a local bus that presents byte addresses within each region.
 */
package card_irq_pkg;
    localparam int unsigned BRIDGE_SIZE = 32;
    localparam int unsigned ANALOG_SIZE = 128;
    localparam int unsigned COUNTER_SIZE = 128;
    localparam logic [6:0] OFS_INTERRUPT_CONTROL_STATUS = 7'h4c;
    localparam logic [6:0] OFS_GENERAL_PURPOSE_CONTROL = 7'h54;
    localparam logic [6:0] OFS_FIFO_FIRST = 7'h00;
    localparam logic [6:0] OFS_FIFO_LAST = 7'h0e;
    localparam logic [6:0] OFS_SOFT_TRIGGER = 7'h20;
    localparam logic [6:0] OFS_ANALOG_OUT_LAST = 7'h2e;
    localparam int unsigned BIT_CONV_EN = 0;
    localparam int unsigned BIT_CONV_POL = 1;
    localparam int unsigned BIT_CONV_STAT = 2;
    localparam int unsigned BIT_CTR_EN = 3;
    localparam int unsigned BIT_CTR_POL = 4;
    localparam int unsigned BIT_CTR_STAT = 5;
    localparam int unsigned BIT_PCI_EN = 6;
    localparam int unsigned BIT_SOFT_IRQ = 7;
    localparam int unsigned BIT_CONV_EDGE = 8;
    localparam int unsigned BIT_CTR_EDGE = 9;
    localparam int unsigned BIT_CONV_CLR = 10;
    localparam int unsigned BIT_CTR_CLR = 11;
    localparam int unsigned BIT_CONV_DONE = 17;
    localparam int unsigned BIT_LOAD = 23;
    localparam logic [31:0] INTERRUPT_CONTROL_STATUS_RESERVED = 32'h0000_0000;
    localparam logic [31:0] GPC_RESERVED = 32'h0040_06c0;
    localparam logic [15:0] ANALOG_OUT_RESET = 16'h3fff;
    typedef enum logic [2:0] {
        ACC_IDLE = 3'b001,
        ACC_LOW = 3'b010,
        ACC_HIGH = 3'b100
    } acc_state_t;
endpackage

// ==== verilog/card_irq_ctrl.sv ====
/*
 * Interrupt/status control, general-purpose control and region decode
 * with 32-to-16 split for the analog region.
 * Assumes host accesses arrive as one-cycle strobes synchronous to mclk
 * and that the host keeps address and data stable until ack.
 */
//
// Overview of operation
// - Bit 0 enables converter interrupt source
// - Bit 1 selects converter polarity, low advised
// - Bit 2 shows converter interrupt active
// - Bit 3 enables counter/trigger interrupt source
// - Bit 4 selects counter interrupt polarity
// - Bit 5 shows counter interrupt active
// - Bit 6 masters the PCI interrupt
// - Bit 7 software interrupt, needs bit 6
// - Bit 8 converter edge mode, high polarity only
// - Bit 9 counter edge mode, high polarity only
// - Write bit 10 clears converter edge latch
// - Write bit 11 clears counter edge latch
// - Bit 17 reads conversion-done, active low
// - Bit 23 drives analog output load strobe
// - Decode bridge 32, analog 128, counter 128
// - 32-bit analog access becomes two 16-bit cycles
// - Offsets 0x00..0x0e mirror converter FIFO data
// - Read 0x20 triggers, write loads output 0
`timescale 1ns/10ps
module card_irq_ctrl
    import card_irq_pkg::*;
#(
    parameter int unsigned ADDR_W = 7
) (
    input wire logic mclk, // 10 MHz clock
    input wire logic reset_n, // Synchronous reset
    input wire logic [2:0] region_sel, // One-hot: bridge, analog, counter
    input wire logic [ADDR_W-1:0] addr, // Byte offset in region
    input wire logic req, // Access request pulse
    input wire logic wr, // 1 write, 0 read
    input wire logic wide, // 1 for 32-bit access
    input wire logic [31:0] wdata, // Write data
    input wire logic conversion_done_n, // Converter end of last conversion
    input wire logic counter_irq_src, // Counter 4 out or ext trigger
    input wire logic [15:0] fifo_rdata, // Converter FIFO head
    input wire logic [31:0] counter_rdata, // Counter region read data
    output logic [31:0] rdata, // Read data
    output logic ack, // Access done pulse
    output logic inta_n, // PCI interrupt, active low
    output logic analog_out_load_n, // Analog output load strobe
    output logic fifo_pop, // Converter FIFO read pulse
    output logic converter_soft_trigger, // Conversion start pulse
    output logic chan_we, // Channel select write pulse
    output logic [7:0] converter_channel_select, // Channel scan list
    output logic dac_we, // Analog output write pulse
    output logic [2:0] dac_chan, // Analog output channel
    output logic [15:0] dac_data, // Analog output data
    output logic counter_req, // Counter region access pulse
    output logic [ADDR_W-1:0] counter_addr // Counter region address
);
    import card_irq_pkg::*;

    if (ADDR_W != 7) begin : g_bad_width
        $error("ADDR_W must be 7 to cover a 128-byte region");
    end

    logic [11:0] ics_q, ics_d;
    logic conv_lat_q, conv_lat_d, ctr_lat_q, ctr_lat_d;
    logic conv_prev_q, conv_prev_d, ctr_prev_q, ctr_prev_d;
    logic load_q, load_d, inta_n_q, inta_n_d;
    logic conv_act, ctr_act, conv_lvl, ctr_lvl, bridge_wr;

    // Source levels after polarity selection
    assign conv_lvl = ics_q[BIT_CONV_POL] ? conversion_done_n
                                          : !conversion_done_n;
    assign ctr_lvl = ics_q[BIT_CTR_POL] ? counter_irq_src
                                        : !counter_irq_src;
    // Edge mode only meaningful with high polarity
    assign conv_act = (ics_q[BIT_CONV_EDGE] && ics_q[BIT_CONV_POL]) ?
                      conv_lat_q : conv_lvl;
    assign ctr_act = (ics_q[BIT_CTR_EDGE] && ics_q[BIT_CTR_POL]) ?
                     ctr_lat_q : ctr_lvl;
    assign bridge_wr = req && wr && region_sel[0];

    always_comb begin
        ics_d = ics_q;
        load_d = load_q;
        conv_prev_d = conv_lvl;
        ctr_prev_d = ctr_lvl;
        conv_lat_d = conv_lat_q;
        ctr_lat_d = ctr_lat_q;
        if (bridge_wr && addr == OFS_INTERRUPT_CONTROL_STATUS) begin
            ics_d[BIT_CONV_EN] = wdata[BIT_CONV_EN];
            ics_d[BIT_CONV_POL] = wdata[BIT_CONV_POL];
            ics_d[BIT_CTR_EN] = wdata[BIT_CTR_EN];
            ics_d[BIT_CTR_POL] = wdata[BIT_CTR_POL];
            ics_d[BIT_PCI_EN] = wdata[BIT_PCI_EN];
            ics_d[BIT_SOFT_IRQ] = wdata[BIT_SOFT_IRQ];
            ics_d[BIT_CONV_EDGE] = wdata[BIT_CONV_EDGE];
            ics_d[BIT_CTR_EDGE] = wdata[BIT_CTR_EDGE];
            if (wdata[BIT_CONV_CLR])
                conv_lat_d = 1'b0;
            if (wdata[BIT_CTR_CLR])
                ctr_lat_d = 1'b0;
        end
        if (bridge_wr && addr == OFS_GENERAL_PURPOSE_CONTROL)
            load_d = wdata[BIT_LOAD];
        // Set wins over a clear in the same cycle
        if (conv_lvl && !conv_prev_q)
            conv_lat_d = 1'b1;
        if (ctr_lvl && !ctr_prev_q)
            ctr_lat_d = 1'b1;
        ics_d[BIT_CONV_STAT] = conv_act;
        ics_d[BIT_CTR_STAT] = ctr_act;
        ics_d[BIT_CONV_CLR] = 1'b0;
        ics_d[BIT_CTR_CLR] = 1'b0;
        inta_n_d = !(ics_q[BIT_PCI_EN] &&
                     ((ics_q[BIT_CONV_EN] && conv_act) ||
                      (ics_q[BIT_CTR_EN] && ctr_act) ||
                      ics_q[BIT_SOFT_IRQ]));
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ics_q <= '0;
            conv_lat_q <= 1'b0;
            ctr_lat_q <= 1'b0;
            conv_prev_q <= 1'b0;
            // Idle pin low reads high at low polarity; no false edge
            ctr_prev_q <= 1'b1;
            load_q <= 1'b0;
            inta_n_q <= 1'b1;
        end else begin
            ics_q <= ics_d;
            conv_lat_q <= conv_lat_d;
            ctr_lat_q <= ctr_lat_d;
            conv_prev_q <= conv_prev_d;
            ctr_prev_q <= ctr_prev_d;
            load_q <= load_d;
            inta_n_q <= inta_n_d;
        end
    end
    assign inta_n = inta_n_q;
    assign analog_out_load_n = load_q;

    // Access sequencer; analog 32-bit splits into low then high half
    acc_state_t st_q, st_d;
    logic [31:0] rdata_q, rdata_d, wd_q, wd_d;
    logic [ADDR_W-1:0] ad_q, ad_d, cad_q, cad_d;
    logic wr_q, wr_d, wide_q, wide_d, ack_q, ack_d;
    logic pop_q, pop_d, trig_q, trig_d, cwe_q, cwe_d, dwe_q, dwe_d;
    logic creq_q, creq_d;
    logic [7:0] csel_q, csel_d;
    logic [2:0] dch_q, dch_d;
    logic [15:0] dd_q, dd_d, half_rd;
    logic [15:0] half_wd;

    always_comb begin
        half_rd = 16'h0000;
        if (ad_q <= OFS_FIFO_LAST)
            half_rd = fifo_rdata;
        else if (ad_q == OFS_SOFT_TRIGGER)
            half_rd = 16'h0000;
    end
    assign half_wd = (st_q == ACC_HIGH) ? wd_q[31:16] : wd_q[15:0];

    always_comb begin
        st_d = st_q;
        rdata_d = rdata_q;
        wd_d = wd_q;
        ad_d = ad_q;
        cad_d = cad_q;
        wr_d = wr_q;
        wide_d = wide_q;
        ack_d = 1'b0;
        pop_d = 1'b0;
        trig_d = 1'b0;
        cwe_d = 1'b0;
        dwe_d = 1'b0;
        creq_d = 1'b0;
        csel_d = csel_q;
        dch_d = dch_q;
        dd_d = dd_q;
        case (st_q)
            ACC_IDLE: begin
                if (req) begin
                    case (region_sel)
                        3'b001: begin
                            ack_d = 1'b1;
                            rdata_d = 32'h0000_0000;
                            if (addr == OFS_INTERRUPT_CONTROL_STATUS)
                                rdata_d = INTERRUPT_CONTROL_STATUS_RESERVED |
                                          {20'h00000, ics_q};
                            else if (addr == OFS_GENERAL_PURPOSE_CONTROL) begin
                                rdata_d = GPC_RESERVED;
                                rdata_d[BIT_CONV_DONE] =
                                    conversion_done_n;
                                rdata_d[BIT_LOAD] = load_q;
                            end
                        end
                        3'b010: begin
                            st_d = ACC_LOW;
                            ad_d = addr;
                            wd_d = wdata;
                            wr_d = wr;
                            wide_d = wide;
                            rdata_d = 32'h0000_0000;
                        end
                        3'b100: begin
                            creq_d = 1'b1;
                            cad_d = addr;
                            st_d = ACC_HIGH;
                            wide_d = 1'b0;
                            ad_d = '1;
                        end
                        default: ack_d = 1'b1;
                    endcase
                end
            end
            ACC_LOW, ACC_HIGH: begin
                if (ad_q == '1) begin
                    // Counter region access, one cycle of latency
                    rdata_d = counter_rdata;
                    ack_d = 1'b1;
                    st_d = ACC_IDLE;
                end else begin
                    if (wr_q) begin
                        if (ad_q == OFS_FIFO_FIRST) begin
                            cwe_d = 1'b1;
                            csel_d = half_wd[7:0];
                        end else if (ad_q >= OFS_SOFT_TRIGGER &&
                                     ad_q <= OFS_ANALOG_OUT_LAST) begin
                            dwe_d = 1'b1;
                            dch_d = ad_q[3:1];
                            dd_d = half_wd;
                        end
                    end else begin
                        if (ad_q <= OFS_FIFO_LAST)
                            pop_d = 1'b1;
                        if (ad_q == OFS_SOFT_TRIGGER)
                            trig_d = 1'b1;
                        if (st_q == ACC_HIGH)
                            rdata_d[31:16] = half_rd;
                        else
                            rdata_d[15:0] = half_rd;
                    end
                    if (st_q == ACC_LOW && wide_q) begin
                        st_d = ACC_HIGH;
                        ad_d = ad_q + 7'd2;
                    end else begin
                        ack_d = 1'b1;
                        st_d = ACC_IDLE;
                    end
                end
            end
            default: st_d = ACC_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_q <= ACC_IDLE;
            rdata_q <= '0;
            wd_q <= '0;
            ad_q <= '0;
            cad_q <= '0;
            wr_q <= 1'b0;
            wide_q <= 1'b0;
            ack_q <= 1'b0;
            pop_q <= 1'b0;
            trig_q <= 1'b0;
            cwe_q <= 1'b0;
            dwe_q <= 1'b0;
            creq_q <= 1'b0;
            csel_q <= '0;
            dch_q <= '0;
            dd_q <= ANALOG_OUT_RESET;
        end else begin
            st_q <= st_d;
            rdata_q <= rdata_d;
            wd_q <= wd_d;
            ad_q <= ad_d;
            cad_q <= cad_d;
            wr_q <= wr_d;
            wide_q <= wide_d;
            ack_q <= ack_d;
            pop_q <= pop_d;
            trig_q <= trig_d;
            cwe_q <= cwe_d;
            dwe_q <= dwe_d;
            creq_q <= creq_d;
            csel_q <= csel_d;
            dch_q <= dch_d;
            dd_q <= dd_d;
        end
    end
    assign rdata = rdata_q;
    assign ack = ack_q;
    assign fifo_pop = pop_q;
    assign converter_soft_trigger = trig_q;
    assign chan_we = cwe_q;
    assign converter_channel_select = csel_q;
    assign dac_we = dwe_q;
    assign dac_chan = dch_q;
    assign dac_data = dd_q;
    assign counter_req = creq_q;
    assign counter_addr = cad_q;
endmodule

// ==== verification/card_far_side.sv ====
/* Far side model: converter FIFO and counter block.
   Assumes strobes from the block are synchronous to mclk. */
`timescale 1ns/10ps
module card_far_side (
    input wire logic mclk, // Clock
    input wire logic fifo_pop, // Pop strobe
    input wire logic counter_req, // Counter access
    input wire logic [6:0] counter_addr, // Counter offset
    output logic [15:0] fifo_rdata, // FIFO head
    output logic [31:0] counter_rdata // Counter data
);
    logic [15:0] cnt_q = 16'h0;
    logic [31:0] stale_q = 32'h0;
    // Fall-through: pop strobe already shows the next entry
    assign fifo_rdata = 16'ha000 + cnt_q + {15'h0, fifo_pop};
    // Answers while the request stands; the block samples it then
    assign counter_rdata = counter_req ? {25'h0a5a5a5, counter_addr}
        : stale_q;
    always_ff @(posedge mclk) begin
        cnt_q <= cnt_q + {15'h0, fifo_pop};
        // Stale data inverts each cycle so a late sample shows up
        stale_q <= ~stale_q;
    end
endmodule

// ==== verification/card_irq_monitor.sv ====
/* Port checker for card_irq_ctrl, bound at the foot.
   Assumes requests only while idle, one cycle long. */
`timescale 1ns/10ps
module card_irq_monitor
    import card_irq_pkg::*;
#(
    parameter int unsigned ADDR_W = 7
) (
    input wire logic mclk, // Clock
    input wire logic reset_n, // Reset
    input wire logic [2:0] region_sel, // Region
    input wire logic [ADDR_W-1:0] addr, // Offset
    input wire logic req, // Request
    input wire logic wr, // Write
    input wire logic wide, // Wide
    input wire logic [31:0] wdata, // Data
    input wire logic ack, // Done
    input wire logic inta_n, // Interrupt
    input wire logic analog_out_load_n, // Load
    input wire logic fifo_pop, // Pop
    input wire logic converter_soft_trigger, // Trigger
    input wire logic dac_we, // DAC write
    input wire logic [2:0] dac_chan, // DAC channel
    input wire logic [15:0] dac_data, // DAC data
    input wire logic [ADDR_W-1:0] counter_addr // Counter offset
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    sequence s_csr;
        req && region_sel == 3'b001 && wr
            && addr == OFS_INTERRUPT_CONTROL_STATUS;
    endsequence
    sequence s_ana(logic w);
        req && region_sel == 3'b010 && wr == w;
    endsequence
    sequence s_pops;
        fifo_pop ##1 (fifo_pop && ack);
    endsequence
    property p_ack; ack |=> !ack; endproperty
    a_ack: assert property (p_ack) else $error("ack held");
    property p_bridge; req && region_sel == 3'b001 |=> ack; endproperty
    a_bridge: assert property (p_bridge) else $error("bridge ack");
    property p_wide;
        s_ana(1'b0) ##0 (wide && addr <= OFS_FIFO_LAST) |=> !ack ##1 s_pops;
    endproperty
    a_wide: assert property (p_wide) else $error("split read");
    property p_trig;
        s_ana(1'b0) ##0 (!wide && addr == OFS_SOFT_TRIGGER)
            |=> ##1 (converter_soft_trigger && ack);
    endproperty
    a_trig: assert property (p_trig) else $error("no trigger");
    property p_dac;
        s_ana(1'b1) ##0 (!wide && addr[6:4] == 3'h2 && !addr[0])
            |=> ##1 (dac_we && dac_chan == $past(addr[3:1], 2)
            && dac_data == $past(wdata[15:0], 2));
    endproperty
    a_dac: assert property (p_dac) else $error("dac write");
    property p_off; s_csr ##0 !wdata[BIT_PCI_EN] |=> ##2 inta_n; endproperty
    a_off: assert property (p_off) else $error("irq unmasked");
    property p_soft; s_csr ##0 wdata[7:6] == 2'b11 |=> ##2 !inta_n; endproperty
    a_soft: assert property (p_soft) else $error("no soft irq");
    property p_load;
        req && region_sel == 3'b001 && wr && addr == OFS_GENERAL_PURPOSE_CONTROL
            |=> ##1 analog_out_load_n == $past(wdata[BIT_LOAD], 2);
    endproperty
    a_load: assert property (p_load) else $error("load strobe");
    property p_ctr;
        req && region_sel == 3'b100
            |=> ##1 (ack && counter_addr == $past(addr, 2));
    endproperty
    a_ctr: assert property (p_ctr) else $error("counter fwd");
endmodule
bind card_irq_ctrl card_irq_monitor #(.ADDR_W(ADDR_W)) u_monitor (
    .mclk, .reset_n, .region_sel, .addr, .req, .wr, .wide, .wdata, .ack,
    .inta_n, .analog_out_load_n, .fifo_pop, .converter_soft_trigger,
    .dac_we, .dac_chan, .dac_data, .counter_addr);

// ==== verification/tb_card_irq_ctrl.sv ====
/* Self-checking bench for card_irq_ctrl with far side model.
   Assumes package, model and checker compile first. */
`timescale 1ns/10ps
module tb_card_irq_ctrl;
    import card_irq_pkg::*;
    logic mclk = 1'b0, reset_n = 1'b0, req = 1'b0, wr = 1'b0, wide = 1'b0;
    logic conversion_done_n = 1'b1, counter_irq_src = 1'b0;
    logic [2:0] region_sel = 3'b001;
    logic [6:0] addr = 7'h0;
    logic [31:0] wdata = 32'h0, rdata, counter_rdata, q, d, e;
    logic ack, inta_n, analog_out_load_n, fifo_pop, converter_soft_trigger;
    logic chan_we, dac_we, counter_req;
    logic [7:0] converter_channel_select;
    logic [2:0] dac_chan;
    logic [15:0] dac_data, fifo_rdata;
    logic [6:0] counter_addr;
    logic [18:0] dac_q[$], exp_q[$];
    int fail_count = 0, samples_checked = 0, pops = 0, trig = 0, cyc = 0;
    int fifo_n = 0, seed, wes = 0;
    // Row: {done_n, ctr, inta_n, 0}, write value, 4'h0, status read
    localparam logic [31:0] STEPS[17] = '{
        32'h4041_0045, 32'h6040_0044, 32'h6001_0005,
        32'he080_0080, 32'hc0c0_00c0, 32'ha058_0058,
        32'hc058_0078, 32'ha058_0058, 32'haa58_0258,
        32'hc258_0278, 32'h8258_0278, 32'haa58_0258,
        32'h6543_0143, 32'hc143_0147, 32'h4143_0147,
        32'h6543_0143, 32'he000_0000};
    always #50 mclk = ~mclk;
    card_irq_ctrl u_dut (.mclk, .reset_n, .region_sel, .addr, .req, .wr,
        .wide, .wdata, .conversion_done_n, .counter_irq_src, .fifo_rdata,
        .counter_rdata, .rdata, .ack, .inta_n, .analog_out_load_n, .fifo_pop,
        .converter_soft_trigger, .chan_we, .converter_channel_select, .dac_we,
        .dac_chan, .dac_data, .counter_req, .counter_addr);
    card_far_side u_far (.mclk, .fifo_pop, .counter_req, .counter_addr,
        .fifo_rdata, .counter_rdata);
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic [2:0] r, input logic [6:0] a,
        input logic w, input logic wd, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge mclk);
        region_sel <= r;
        addr <= a;
        wr <= w;
        wide <= wd;
        wdata <= dat;
        req <= 1'b1;
        @(posedge mclk);
        req <= 1'b0;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 8);
        chk({31'h0, ack}, 32'h1);
        q = rdata;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (fifo_pop === 1'b1) pops++;
        if (converter_soft_trigger === 1'b1) trig++;
        if (dac_we === 1'b1) dac_q.push_back({dac_chan, dac_data});
        if (chan_we === 1'b1) wes++;
        if (cyc > 3000) begin
            fail_count++;
            give_verdict();
        end
    end
    initial begin
        seed = $urandom(32'h7451);
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        chk({6'h0, inta_n, analog_out_load_n, converter_channel_select,
            dac_data}, {8'h02, 8'h0, ANALOG_OUT_RESET});
        foreach (STEPS[i]) begin
            conversion_done_n <= STEPS[i][31];
            counter_irq_src <= STEPS[i][30];
            // Let the edge latch settle before any clear lands
            repeat (3) @(posedge mclk);
            acc(3'b001, 7'h4c, 1'b1, 1'b1, {20'h0, STEPS[i][27:16]});
            repeat (3) @(posedge mclk);
            acc(3'b001, 7'h4c, 1'b0, 1'b1, 32'h0);
            chk(q & 32'h3ff, {20'h0, STEPS[i][11:0]});
            chk({31'h0, inta_n}, {31'h0, STEPS[i][29]});
        end
        acc(3'b001, 7'h54, 1'b1, 1'b1, 32'h0080_0000);
        chk({31'h0, analog_out_load_n}, 32'h1);
        acc(3'b001, 7'h54, 1'b0, 1'b1, 32'h0);
        chk(q, GPC_RESERVED | 32'h0082_0000);
        conversion_done_n <= 1'b0;
        repeat (3) @(posedge mclk);
        acc(3'b001, 7'h54, 1'b0, 1'b1, 32'h0);
        chk(q, GPC_RESERVED | 32'h0080_0000);
        acc(3'b010, 7'h04, 1'b0, 1'b1, 32'h0);
        e = 32'ha000 + fifo_n;
        fifo_n += 2;
        chk(q, {e[15:0] + 16'h1, e[15:0]});
        acc(3'b010, 7'(2 * $urandom_range(7)), 1'b0, 1'b0, 32'h0);
        e = 32'ha000 + fifo_n;
        fifo_n++;
        chk({16'h0, q[15:0]}, {16'h0, e[15:0]});
        // Last pulse is counted on the edge that ends the access
        @(negedge mclk);
        chk(pops, fifo_n);
        d = $urandom;
        acc(3'b010, 7'h00, 1'b1, 1'b0, d);
        chk({24'h0, converter_channel_select}, {24'h0, d[7:0]});
        acc(3'b010, 7'h22, 1'b1, 1'b1, d);
        acc(3'b010, 7'h20, 1'b1, 1'b0, ~d);
        exp_q = '{{3'd1, d[15:0]}, {3'd2, d[31:16]}, {3'd0, ~d[15:0]}};
        @(negedge mclk);
        chk(wes, 1);
        chk(dac_q.size(), 3);
        foreach (exp_q[i]) chk({13'h0, dac_q[i]}, {13'h0, exp_q[i]});
        acc(3'b010, 7'h20, 1'b0, 1'b0, 32'h0);
        chk(q, 32'h0);
        @(negedge mclk);
        chk(trig, 1);
        acc(3'b100, 7'h44, 1'b0, 1'b1, 32'h0);
        chk(q, {25'h0a5a5a5, 7'h44});
        acc(3'b001, 7'h10, 1'b0, 1'b1, 32'h0);
        chk(q, 32'h0);
        give_verdict();
    end
endmodule
